// [low_supply_monitor.sv]
// Low supply monitor: control register, flag, qualified interrupt, power gating
// What this block does
// - Three-bit field selects eight trip levels
// - Enabled monitor below threshold raises flag
// - Flag is read only; zero means ok
// - Enable bit powers detector on or off
// - Bandgap on for monitor, reset or buffer
// - Sleep disables detector despite enable bit
// - Request flag set after qualifying delay
// - Pending request wakes from sleep or idle
// - Flag may toggle; consumers must tolerate
// - Control bits seven and six read zero
// - Request bit 7, enable bit 3, read/write
`timescale 1ns/1ps
module low_supply_monitor
    import low_supply_monitor_pkg::*;
(
    input  wire logic        pclk,               // System clock
    input  wire logic        presetn,            // Asynchronous reset, active low
    input  wire logic        psel,               // APB select
    input  wire logic        penable,            // APB access phase
    input  wire logic        pwrite,             // APB direction
    input  wire logic [7:0]  paddr,              // APB byte address
    input  wire logic [31:0] pwdata,             // APB write data
    input  wire logic [3:0]  pstrb,              // APB byte strobes
    output logic      [31:0] prdata,             // APB read data
    output logic             pready,             // APB ready
    output logic             pslverr,            // APB error for unmapped address
    input  wire logic        comparator_low,     // Analog comparator: supply below level
    output logic      [2:0]  threshold_select,   // Trip level code to the analog divider
    output logic             detector_power,     // Detector analog power enable
    output logic             bandgap_enable,     // Shared bandgap reference enable
    output logic             wake_request,       // Wake from sleep or idle
    output logic             irq                 // Level interrupt
);
    logic [7:0] ctrl;                            // Monitor control, writable bits
    logic       low_supply_flag;                 // Synchronised flag
    logic       flag_prev;                       // Flag one cycle ago, edge detect
    logic       low_supply_irq_flag;             // Request flag
    logic       low_supply_irq_enable;           // Request enable
    logic [event_count-1:0] status;              // Sticky events
    logic [event_count-1:0] mask;                // Event mask
    logic       sleep_state;                     // Device asleep
    logic       idle_state;                      // Device idle
    logic       low_voltage_reset;               // Low voltage reset enabled
    logic [qual_width-1:0] qual_cnt;             // Qualifying delay counter
    logic       irq_set;                         // Delay expired this cycle
    logic       detector_on;                     // Combined enable
    logic       wr_access;                       // Write completes this cycle
    logic       rd_access;                       // Read in access phase, wait cycle included
    logic       addr_ok;                         // Address maps to a register
    logic [event_count-1:0] events;              // Event pulses
    logic [31:0] next_prdata;                    // Read mux value

    // Detector is on only when enabled and not asleep
    assign detector_on = ctrl[mon_en_bit] && !sleep_state;
    assign wr_access   = psel && penable && pready && pwrite && pstrb[0]; // Lands where pready is seen high
    assign rd_access   = psel && penable && !pwrite;
    assign addr_ok     = (paddr == ctrl_offset) || (paddr == irq_ctrl_offset) ||
                         (paddr == irq_status_offset) || (paddr == irq_mask_offset) ||
                         (paddr == power_offset);

    // Comparator crosses into the clock domain before any use
    supply_flag_sync u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (comparator_low),
        .enable   (detector_on),
        .sync_out (low_supply_flag)
    );

    // Control register: threshold, buffer, enable; flag bit not writable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= ctrl_reset;
        else if (wr_access && paddr == ctrl_offset)
            ctrl <= {3'b000, pwdata[4:0]};
    end

    // Power state and reset enable inputs from software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_state       <= 1'b0;
            idle_state        <= 1'b0;
            low_voltage_reset <= 1'b0;
        end
        else if (wr_access && paddr == power_offset)
        begin
            sleep_state       <= pwdata[sleep_bit];
            idle_state        <= pwdata[idle_bit];
            low_voltage_reset <= pwdata[lvr_bit];
        end
        else if (wake_request)
        begin
            sleep_state <= 1'b0;
            idle_state  <= 1'b0;
        end
    end

    // Qualifying delay: restarts whenever the flag drops, so toggling is harmless
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            qual_cnt <= '0;
        else if (!low_supply_flag)
            qual_cnt <= '0;
        else if (qual_cnt != qualify_count)
            qual_cnt <= qual_cnt + 1'b1;
    end

    assign irq_set = low_supply_flag && (qual_cnt == qualify_count - 1'b1);

    // Request flag and its enable; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_supply_irq_flag   <= irq_ctrl_reset[irq_flag_bit];
            low_supply_irq_enable <= irq_ctrl_reset[irq_en_bit];
        end
        else
        begin
            if (wr_access && paddr == irq_ctrl_offset)
            begin
                low_supply_irq_flag   <= pwdata[irq_flag_bit] || irq_set;
                low_supply_irq_enable <= pwdata[irq_en_bit];
            end
            else if (irq_set)
                low_supply_irq_flag <= 1'b1;
        end
    end

    // Previous flag for edge events
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_prev <= 1'b0;
        else
            flag_prev <= low_supply_flag;
    end

    assign events[ev_flag_rise] = low_supply_flag && !flag_prev;
    assign events[ev_flag_fall] = !low_supply_flag && flag_prev;
    assign events[ev_irq_set]   = irq_set;

    // Sticky status bits, write one to clear, set wins
    genvar gi;
    generate
        for (gi = 0; gi < event_count; gi++)
        begin : g_status
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    status[gi] <= 1'b0;
                else if (events[gi])
                    status[gi] <= 1'b1;
                else if (wr_access && paddr == irq_status_offset && pwdata[gi])
                    status[gi] <= 1'b0;
            end
        end
    endgenerate

    // Mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask <= '0;
        else if (wr_access && paddr == irq_mask_offset)
            mask <= pwdata[event_count-1:0];
    end

    // Registered outputs to the analog side and the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            threshold_select <= 3'b000;
            detector_power   <= 1'b0;
            bandgap_enable   <= 1'b0;
            wake_request     <= 1'b0;
            irq              <= 1'b0;
        end
        else
        begin
            threshold_select <= ctrl[thr_lsb +: 3];
            detector_power   <= detector_on;
            bandgap_enable   <= ctrl[mon_en_bit] || low_voltage_reset ||
                                ctrl[ref_buf_bit];
            wake_request     <= low_supply_irq_flag && (sleep_state || idle_state);
            irq              <= |(status & mask);
        end
    end

    // Read mux
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            ctrl_offset:
                next_prdata[7:0] = {2'b00, low_supply_flag, ctrl[4:0]};
            irq_ctrl_offset:
            begin
                next_prdata[irq_flag_bit] = low_supply_irq_flag;
                next_prdata[irq_en_bit]   = low_supply_irq_enable;
            end
            irq_status_offset:
                next_prdata[event_count-1:0] = status;
            irq_mask_offset:
                next_prdata[event_count-1:0] = mask;
            power_offset:
                next_prdata[2:0] = {low_voltage_reset, idle_state, sleep_state};
            default:
                next_prdata = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait state, ready and data registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (psel && penable && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= !addr_ok;
            prdata  <= next_prdata;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // Writes commit on the edge where pready is seen high; read data is registered on the edge that raises pready
    logic unused_rd;                             // Read strobe kept for clarity of timing
    assign unused_rd = rd_access;
endmodule

// [low_supply_monitor_pkg.sv]
// Shared constants for the low supply monitor block
package low_supply_monitor_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] ctrl_offset        = 8'h00; // Monitor control register
    localparam logic [7:0] irq_ctrl_offset    = 8'h04; // Interrupt request and enable
    localparam logic [7:0] irq_status_offset  = 8'h08; // Sticky event status, write one to clear
    localparam logic [7:0] irq_mask_offset    = 8'h0c; // Mask gating status onto irq
    localparam logic [7:0] power_offset       = 8'h10; // Sleep state and low voltage reset enable
    // Field positions in the monitor control register
    localparam int thr_lsb                    = 0;     // Threshold select, three bits
    localparam int ref_buf_bit                = 3;     // Reference buffer enable
    localparam int mon_en_bit                 = 4;     // Monitor enable
    localparam int flag_bit                   = 5;     // Low supply flag, read only
    // Field positions in the interrupt control register
    localparam int irq_en_bit                 = 3;     // Interrupt enable
    localparam int irq_flag_bit               = 7;     // Interrupt request flag
    // Field positions in the status and mask registers
    localparam int ev_flag_rise               = 0;     // Low supply flag went high
    localparam int ev_flag_fall               = 1;     // Low supply flag went low
    localparam int ev_irq_set                 = 2;     // Request flag set by the delay
    localparam int event_count                = 3;     // Number of status events
    // Field positions in the power register
    localparam int sleep_bit                  = 0;     // Device in sleep
    localparam int idle_bit                   = 1;     // Device in idle
    localparam int lvr_bit                    = 2;     // Low voltage reset enable
    // Reset values
    localparam logic [7:0] ctrl_reset         = 8'h00;
    localparam logic [7:0] irq_ctrl_reset     = 8'h00;
    // Qualifying delay before the interrupt request, in ns, and in cycles
    localparam int clk_period_ps              = 5000;  // 200 MHz
    localparam int irq_qualify_delay_ns       = 100;
    localparam int qualify_cycles_raw         = (irq_qualify_delay_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
    localparam int qualify_cycles             = (qualify_cycles_raw < 1) ? 1 : qualify_cycles_raw;
    localparam int qual_width                 = 8;
    localparam logic [qual_width-1:0] qualify_count = qual_width'(qualify_cycles);
endpackage

// [supply_flag_sync.sv]
// Three flip-flop synchroniser with agreement filter for the comparator
`timescale 1ns/1ps
module supply_flag_sync
    import low_supply_monitor_pkg::*;
(
    input  wire logic pclk,        // System clock
    input  wire logic presetn,     // Asynchronous reset, active low
    input  wire logic async_in,    // Raw comparator output
    input  wire logic enable,      // Detector active
    output logic      sync_out     // Filtered, clocked level
);
    logic stage1;                  // Metastability catcher, read by stage2 only
    logic stage2;                  // Second stage
    logic stage3;                  // Third stage

    // Shift chain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Output follows once two late stages agree; forced low when off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_out <= 1'b0;
        else if (!enable)
            sync_out <= 1'b0;
        else if (stage2 == stage3)
            sync_out <= stage3;
    end
endmodule

// [low_supply_monitor_chk.sv]
// Port assertions for the low supply monitor
`timescale 1ns/1ps
module low_supply_monitor_chk
    import low_supply_monitor_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        comparator_low,
    input wire logic [2:0]  threshold_select,
    input wire logic        detector_power,
    input wire logic        bandgap_enable,
    input wire logic        wake_request,
    input wire logic        irq
);
    // First access edge of a write that lands
    logic acc;
    assign acc = psel && penable && !pready && pwrite && pstrb[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_reply: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_slverr_unmapped: assert property (pready && paddr > power_offset |-> pslverr)
        else $error("unmapped access not refused");
    a_ctrl_top_zero: assert property (pready && !pwrite && paddr == ctrl_offset |-> prdata[31:6] == 26'h0)
        else $error("control upper bits not zero");
    a_bandgap_cover: assert property (detector_power |-> bandgap_enable)
        else $error("bandgap off with detector on");
    a_thr_write: assert property (acc && paddr == ctrl_offset |-> ##3 threshold_select == $past(pwdata[2:0], 3))
        else $error("threshold not taken");
    a_sleep_gate: assert property (acc && paddr == power_offset && pwdata[sleep_bit] |-> ##3 !detector_power)
        else $error("detector on in sleep");
    a_monitor_off: assert property (acc && paddr == ctrl_offset && !pwdata[mon_en_bit] |-> ##3 !detector_power)
        else $error("detector on when disabled");
    a_flag_gated: assert property ((!detector_power)[*3] ##1 (pready && !pwrite && paddr == ctrl_offset)
        |-> !prdata[flag_bit])
        else $error("flag set with detector off");
    c_refused: cover property (pslverr);
    c_wake: cover property ($rose(wake_request));
    c_irq: cover property ($rose(irq));
endmodule
bind low_supply_monitor low_supply_monitor_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_low(comparator_low), .threshold_select(threshold_select),
    .detector_power(detector_power), .bandgap_enable(bandgap_enable), .wake_request(wake_request), .irq(irq));

// [testbench.sv]
// Self-checking bench for the low supply monitor
`timescale 1ns/1ps
module testbench;
    import low_supply_monitor_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, comparator_low, pready, pslverr, rerr;
    logic        detector_power, bandgap_enable, wake_request, irq;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [2:0]  threshold_select;
    logic [31:0] pwdata, prdata, rdata;
    logic [7:0]  ctl [4] = '{8'h00, 8'h08, 8'h00, 8'h10}; // Control per power case
    logic [7:0]  pwr [4] = '{8'h00, 8'h00, 8'h04, 8'h00}; // Power per case
    int          failures = 0, comparisons = 0, cycles = 0, i;
    low_supply_monitor i_low_supply_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_low(comparator_low), .threshold_select(threshold_select),
        .detector_power(detector_power), .bandgap_enable(bandgap_enable), .wake_request(wake_request), .irq(irq));
    // Clock at 200 MHz
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Verdict and stop
    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            end_of_test();
        end
    end
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 50)
            failures++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hf);
        chk(rdata, e);
    endtask
    // Poll for a wake request, bounded
    task wait_wake;
        int n;
        n = 0;
        @(negedge pclk);
        while (wake_request !== 1'b1 && n < 10)
        begin
            @(negedge pclk);
            n++;
        end
        chk(wake_request, 32'h1);
    endtask
    // Main sequence
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        comparator_low = 1'b0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk({threshold_select, detector_power, bandgap_enable, wake_request, irq}, 32'h0);
        rd(ctrl_offset, 32'h0);
        rd(irq_ctrl_offset, 32'h0);
        rd(irq_status_offset, 32'h0);
        rd(irq_mask_offset, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            wr(ctrl_offset, 32'(i));
            repeat (2) @(negedge pclk);
            chk(threshold_select, 32'(i));
            rd(ctrl_offset, 32'(i));
        end
        apb(1'b1, ctrl_offset, 32'h0, 4'h0);
        rd(ctrl_offset, 32'h7);
        for (i = 0; i < 4; i++)
        begin
            wr(ctrl_offset, 32'(ctl[i]));
            wr(power_offset, 32'(pwr[i]));
            repeat (2) @(negedge pclk);
            chk({bandgap_enable, detector_power}, {ctl[i][3] | ctl[i][4] | pwr[i][2], ctl[i][4]});
        end
        wr(ctrl_offset, 32'hff);
        rd(ctrl_offset, 32'h1f);
        wr(irq_mask_offset, 32'h7);
        repeat (4)
        begin
            comparator_low <= 1'b1;
            repeat (10) @(posedge pclk);
            comparator_low <= 1'b0;
            repeat (10) @(posedge pclk);
        end
        rd(irq_ctrl_offset, 32'h0);
        rd(irq_status_offset, 32'h3);
        wr(irq_status_offset, 32'h7);
        rd(irq_status_offset, 32'h0);
        chk(irq, 32'h0);
        comparator_low <= 1'b1;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk(irq, 32'h1);
        rd(ctrl_offset, 32'h3f);
        rd(irq_ctrl_offset, 32'h0);
        repeat (qualify_cycles) @(posedge pclk);
        rd(irq_ctrl_offset, 32'h80);
        rd(irq_status_offset, 32'h5);
        wr(irq_mask_offset, 32'h0);
        repeat (2) @(negedge pclk);
        chk(irq, 32'h0);
        comparator_low <= 1'b0;
        for (i = 1; i < 3; i++)
        begin
            wr(power_offset, 32'(i));
            wait_wake();
            rd(power_offset, 32'h0);
        end
        wr(irq_ctrl_offset, 32'h8);
        rd(irq_ctrl_offset, 32'h8);
        wr(power_offset, 32'h1);
        comparator_low <= 1'b1;
        repeat (qualify_cycles + 8) @(posedge pclk);
        @(negedge pclk);
        chk({wake_request, detector_power}, 32'h0);
        rd(ctrl_offset, 32'h1f);
        rd(irq_ctrl_offset, 32'h8);
        wr(power_offset, 32'h0);
        comparator_low <= 1'b0;
        rd(8'h14, 32'h0);
        chk(rerr, 32'h1);
        end_of_test();
    end
endmodule
